// [bench/mah_chk.sv]
// concurrent checks on the attribute handler ports
module mah_chk import mah_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire mah_cmd_t cmd,
  input wire mah_rsp_t rsp,
  input wire logic rsp_valid,
  input wire logic profile_busy,
  input wire logic on_target,
  input wire logic signed [31:0] measured_speed,
  input wire logic start_move,
  input wire logic position_load,
  input wire logic signed [31:0] position_load_value,
  input wire logic armed,
  input wire logic signed [31:0] latched_position
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_get(logic [7:0] a);
    cmd_valid && cmd.object_sel == MAH_OBJ_POSC && cmd.get_attr == a;
  endsequence
  a_rsp_follows: assert property (cmd_valid |=> rsp_valid)
    else $error("no response after command");
  a_rsp_no_spur: assert property (!cmd_valid |=> !rsp_valid)
    else $error("response without command");
  a_busy_bit: assert property (rsp_valid |-> rsp.flags[MAH_RB_BUSY] == $past(profile_busy))
    else $error("busy bit wrong");
  a_on_tgt_bit: assert property (rsp_valid |-> rsp.flags[MAH_RB_ON_TGT] == $past(on_target))
    else $error("on target bit wrong");
  a_attr_count: assert property (s_get(MAH_PA_NUM_ATTR) |=> rsp.value == MAH_NUM_ATTR_VAL)
    else $error("attribute count wrong");
  a_speed_get: assert property (s_get(MAH_PA_ACT_VEL) |=> rsp.value == $past(measured_speed))
    else $error("velocity read wrong");
  // only a command with the load bit set on the controller object may start a move
  a_start_cause: assert property (start_move |-> $past(cmd_valid)
    && $past(cmd.flags[MAH_CB_LOAD]) && $past(cmd.object_sel) == MAH_OBJ_POSC)
    else $error("start without load");
  a_home_write: assert property (position_load |-> $past(cmd.set_attr) == MAH_PA_ACT_POS
    && position_load_value == $past(cmd.value))
    else $error("position overwrite wrong");
  a_capture_armed: assert property ($changed(latched_position) |-> $past(armed) && !armed)
    else $error("capture while disarmed");
endmodule

bind mah_top mah_chk mah_chk_inst (
  .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd), .rsp(rsp),
  .rsp_valid(rsp_valid), .profile_busy(profile_busy), .on_target(on_target),
  .measured_speed(measured_speed), .start_move(start_move), .position_load(position_load),
  .position_load_value(position_load_value), .armed(armed), .latched_position(latched_position)
);

// [bench/mah_master.sv]
// fieldbus master model issuing implicit command messages
module mah_master import mah_pkg::*; (
  output logic cmd_valid,
  output mah_cmd_t cmd,
  input wire logic clk
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  task automatic send(logic [4:0] obj, logic [7:0] ga, logic [7:0] sa, logic [7:0] fl,
      logic [31:0] val);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd = '{fl, ga, MAH_INST_ONE, obj, sa, val};
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    // bytes mean nothing between messages, so they toggle
    cmd = ~cmd;
  endtask
endmodule

// [bench/tb_motion_attribute_handler.sv]
// self-checking bench for the motion attribute handler
module tb_motion_attribute_handler;
  timeunit 1ns;
  timeprecision 1ps;
  import mah_pkg::*;
  typedef struct packed {
    logic [4:0] obj;
    logic [7:0] ga;
    logic [7:0] sa;
    logic [7:0] fl;
    logic [31:0] val;
    logic [31:0] exp;
  } mah_row_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic home_pin = 1'b1;
  logic reg_pin = 1'b0;
  logic profile_busy = 1'b0;
  logic on_target = 1'b0;
  logic signed [31:0] measured_position = 32'h00000309;
  logic signed [31:0] measured_speed = 32'hffffcfc7;
  logic cmd_valid, rsp_valid, start_move, position_load, armed;
  mah_cmd_t cmd;
  mah_rsp_t rsp;
  mah_profile_t profile;
  logic signed [31:0] position_load_value, latched_position;
  int failures = 0;
  int samples_checked = 0;
  logic load_seen = 1'b0;
  mah_row_t rows [28] = '{
    '{5'h1b, 8'h03, 8'h03, 8'h01, 32'h2, 32'h0},
    '{5'h1b, 8'h03, 8'h06, 8'h00, 32'h25, 32'h2},
    '{5'h1b, 8'h06, 8'h06, 8'h01, 32'hfffffffb, 32'h0},
    '{5'h1b, 8'h06, 8'h07, 8'h00, 32'h0, 32'hfffffffb},
    '{5'h1b, 8'h07, 8'h07, 8'h01, 32'h00f42400, 32'h1},
    '{5'h1b, 8'h07, 8'h08, 8'h00, 32'h0, 32'h00f42400},
    '{5'h1b, 8'h08, 8'h08, 8'h01, 32'h3b9aca00, 32'h64},
    '{5'h1b, 8'h08, 8'h09, 8'h00, 32'h0, 32'h3b9aca00},
    '{5'h1b, 8'h09, 8'h09, 8'h01, 32'hc8, 32'h64},
    '{5'h1b, 8'h09, 8'h0a, 8'h00, 32'h0, 32'hc8},
    '{5'h1b, 8'h0a, 8'h01, 8'h05, 32'h7, 32'h0},
    '{5'h1b, 8'h0a, 8'h00, 8'h04, 32'h0, 32'h1},
    '{5'h1b, 8'h01, 8'h0c, 8'h04, 32'h0, 32'h2f},
    '{5'h1b, 8'h0a, 8'h0b, 8'h00, 32'h0, 32'h1},
    '{5'h1b, 8'h03, 8'h03, 8'h01, 32'h3, 32'h2},
    '{5'h1b, 8'h03, 8'h0d, 8'h00, 32'h0, 32'h2},
    '{5'h1b, 8'h0d, 8'h0d, 8'h01, 32'h0, 32'h309},
    '{5'h1b, 8'h0e, 8'h00, 8'h00, 32'h0, 32'hffffcfc7},
    '{5'h1a, 8'h10, 8'h00, 8'h40, 32'h0, 32'h1},
    '{5'h1a, 8'h15, 8'h00, 8'h40, 32'h0, 32'h1},
    '{5'h1a, 8'h16, 8'h00, 8'h40, 32'h0, 32'h0},
    '{5'h1c, 8'h03, 8'h00, 8'h40, 32'h0, 32'h0},
    '{5'h1a, 8'h18, 8'h00, 8'h40, 32'h0, 32'h0},
    '{5'h1a, 8'h15, 8'h15, 8'h01, 32'h1, 32'h1},
    '{5'h1a, 8'h15, 8'h00, 8'h00, 32'h0, 32'h1},
    '{5'h1a, 8'h15, 8'h00, 8'h40, 32'h0, 32'h0},
    '{5'h1b, 8'h0a, 8'h0a, 8'h41, 32'h1, 32'h0},
    '{5'h1b, 8'h0a, 8'h00, 8'h40, 32'h0, 32'h1}
  };

  always #4 clk = ~clk;

  mah_master mah_master_inst (.cmd_valid(cmd_valid), .cmd(cmd), .clk(clk));
  mah_top mah_top_inst (
    .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd), .rsp(rsp),
    .rsp_valid(rsp_valid), .home_pin(home_pin), .reg_pin(reg_pin),
    .profile_busy(profile_busy), .on_target(on_target),
    .measured_position(measured_position), .measured_speed(measured_speed),
    .profile(profile), .start_move(start_move), .position_load(position_load),
    .position_load_value(position_load_value), .armed(armed),
    .latched_position(latched_position)
  );

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic xfer(mah_row_t r);
    logic edge_exp;
    logic pl_exp;
    edge_exp = (r.obj == MAH_OBJ_POSC) && r.fl[MAH_CB_LOAD] && !load_seen;
    pl_exp = edge_exp && (r.sa == MAH_PA_ACT_POS);
    load_seen = r.fl[MAH_CB_LOAD];
    mah_master_inst.send(r.obj, r.ga, r.sa, r.fl, r.val);
    chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
    chk("rsp value", r.exp, rsp.value);
    chk("start_move", {31'h0, edge_exp}, {31'h0, start_move});
    chk("position_load", {31'h0, pl_exp}, {31'h0, position_load});
  endtask

  initial begin
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    chk("speed reset", MAH_SPEED_RST, profile.speed);
    chk("accel reset", MAH_RATE_RST, profile.accel);
    // pin synchronisers need two edges before the home level shows
    repeat (2) @(posedge clk);
    for (int i = 0; i < 28; i++) begin
      profile_busy = i[0];
      on_target = i[1];
      xfer(rows[i]);
      chk("home bit", 32'h1, {31'h0, rsp.flags[MAH_RB_HOME]});
    end
    chk("target", 32'hfffffffb, profile.target);
    chk("decel", 32'hc8, profile.decel);
    chk("mode", 32'h2, {30'h0, profile.mode});
    $display("test table done");
    // pin passes two flops, so allow a few cycles
    @(posedge clk);
    #1;
    reg_pin = 1'b1;
    for (int n = 0; armed !== 1'b0; n++) begin
      if (n == 10) begin
        failures++;
        conclude();
      end
      @(posedge clk);
      #1;
    end
    chk("latched", 32'h309, latched_position);
    measured_position = 32'h5;
    reg_pin = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    reg_pin = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk("latched kept", 32'h309, latched_position);
    xfer('{5'h1a, MAH_SA_LATCHED_POS, 8'h00, 8'h00, 32'h0, 32'h309});
    chk("reg bit", 32'h1, {31'h0, rsp.flags[MAH_RB_REG]});
    $display("test registration done");
    reset = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
    chk("mode after reset", 32'h0, {30'h0, profile.mode});
    chk("arm after reset", 32'h0, {31'h0, armed});
    $display("test reset done");
    conclude();
  end
endmodule

// [src/mah_capture.sv]
// registration arm flag and position capture
module mah_capture import mah_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_rise,
  input wire logic signed [31:0] position,
  input wire logic arm_load,
  input wire logic arm_value,
  output logic armed,
  output logic signed [31:0] latched_position
);
  logic armed_q;
  logic armed_d;
  logic signed [31:0] pos_q;
  logic signed [31:0] pos_d;

  always_comb begin
    armed_d = armed_q;
    pos_d = pos_q;
    if (arm_load) begin
      armed_d = arm_value;
    end
    if (armed_q && reg_rise) begin
      pos_d = position;
      armed_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      armed_q <= 1'b0;
      pos_q <= 32'sh0;
    end else begin
      armed_q <= armed_d;
      pos_q <= pos_d;
    end
  end

  assign armed = armed_q;
  assign latched_position = pos_q;
endmodule

// [src/mah_pkg.sv]
// shared constants and types for the motion attribute handler
package mah_pkg;
  localparam logic [4:0] MAH_OBJ_SUPER = 5'h1a;
  localparam logic [4:0] MAH_OBJ_POSC = 5'h1b;
  localparam logic [2:0] MAH_INST_ONE = 3'h1;
  // supervisor attribute ids
  localparam logic [7:0] MAH_SA_HOME_LEVEL = 8'h10;
  localparam logic [7:0] MAH_SA_REG_ARM = 8'h15;
  localparam logic [7:0] MAH_SA_REG_LEVEL = 8'h16;
  localparam logic [7:0] MAH_SA_LATCHED_POS = 8'h18;
  // position controller attribute ids
  localparam logic [7:0] MAH_PA_NUM_ATTR = 8'h01;
  localparam logic [7:0] MAH_PA_MODE = 8'h03;
  localparam logic [7:0] MAH_PA_TARGET = 8'h06;
  localparam logic [7:0] MAH_PA_SPEED = 8'h07;
  localparam logic [7:0] MAH_PA_ACCEL = 8'h08;
  localparam logic [7:0] MAH_PA_DECEL = 8'h09;
  localparam logic [7:0] MAH_PA_INCR = 8'h0a;
  localparam logic [7:0] MAH_PA_LOAD = 8'h0b;
  localparam logic [7:0] MAH_PA_ON_TARGET = 8'h0c;
  localparam logic [7:0] MAH_PA_ACT_POS = 8'h0d;
  localparam logic [7:0] MAH_PA_ACT_VEL = 8'h0e;
  localparam logic [31:0] MAH_NUM_ATTR_VAL = 32'h0000002f;
  // command byte 0 bit positions
  localparam int MAH_CB_LOAD = 0;
  localparam int MAH_CB_INCR = 2;
  localparam int MAH_CB_ARM = 6;
  // response byte 0 bit positions
  localparam int MAH_RB_BUSY = 0;
  localparam int MAH_RB_ON_TGT = 2;
  localparam int MAH_RB_HOME = 5;
  localparam int MAH_RB_REG = 6;
  // reset values
  localparam logic [1:0] MAH_MODE_RST = 2'h0;
  localparam logic [31:0] MAH_SPEED_RST = 32'h00000001;
  localparam logic [31:0] MAH_RATE_RST = 32'h00000064;

  typedef enum logic [1:0] {
    MAH_MODE_POSITION,
    MAH_MODE_VELOCITY,
    MAH_MODE_TORQUE
  } mah_mode_t;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] get_attr;
    logic [2:0] instance_sel;
    logic [4:0] object_sel;
    logic [7:0] set_attr;
    logic [31:0] value;
  } mah_cmd_t;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] get_attr;
    logic [7:0] object_echo;
    logic [7:0] ok;
    logic [31:0] value;
  } mah_rsp_t;

  typedef struct packed {
    logic signed [31:0] target;
    logic [31:0] speed;
    logic [31:0] accel;
    logic [31:0] decel;
    logic incremental;
    logic [1:0] mode;
  } mah_profile_t;
endpackage

// [src/mah_sync.sv]
// two-flop synchroniser with a rising edge pulse behind it
module mah_sync import mah_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;

  always_comb begin
    sh_d = {sh_q[1:0], pin};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sh_q <= 3'h0;
    end else begin
      sh_q <= sh_d;
    end
  end

  // first stage feeds only the second
  assign level = sh_q[1];
  assign rise = sh_q[1] & ~sh_q[2];
endmodule

// [src/mah_top.sv]
// attribute get/set interpreter for implicit command messages
module mah_top import mah_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire mah_cmd_t cmd,
  output mah_rsp_t rsp,
  output logic rsp_valid,
  input wire logic home_pin,
  input wire logic reg_pin,
  input wire logic profile_busy,
  input wire logic on_target,
  input wire logic signed [31:0] measured_position,
  input wire logic signed [31:0] measured_speed,
  output mah_profile_t profile,
  output logic start_move,
  output logic position_load,
  output logic signed [31:0] position_load_value,
  output logic armed,
  output logic signed [31:0] latched_position
);
  logic home_level;
  logic reg_level;
  logic reg_rise;
  logic load_q;
  logic load_d;
  logic load_rise;
  logic obj_ok;
  logic set_super;
  logic set_posc;
  mah_profile_t prof_q;
  mah_profile_t prof_d;
  mah_rsp_t rsp_q;
  mah_rsp_t rsp_d;
  logic rsp_valid_q;
  logic start_q;
  logic start_d;
  logic pload_q;
  logic pload_d;
  logic signed [31:0] pval_q;
  logic signed [31:0] pval_d;
  logic arm_load;
  logic arm_value;
  logic get_hit;
  logic [31:0] get_val;

  mah_sync u_home (
    .clk(clk),
    .reset(reset),
    .pin(home_pin),
    .level(home_level),
    .rise()
  );

  mah_sync u_reg (
    .clk(clk),
    .reset(reset),
    .pin(reg_pin),
    .level(reg_level),
    .rise(reg_rise)
  );

  mah_capture u_cap (
    .clk(clk),
    .reset(reset),
    .reg_rise(reg_rise),
    .position(measured_position),
    .arm_load(arm_load),
    .arm_value(arm_value),
    .armed(armed),
    .latched_position(latched_position)
  );

  // decodes the get attribute for the chosen object
  function automatic logic [32:0] read_attr(input logic [4:0] obj, input logic [7:0] id,
      input mah_profile_t p, input logic [3:0] bits, input logic signed [31:0] lpos,
      input logic signed [31:0] apos, input logic signed [31:0] avel);
    logic [32:0] r;
    r = 33'h0;
    if (obj == MAH_OBJ_SUPER) begin
      case (id)
        MAH_SA_HOME_LEVEL: r = {1'b1, 31'h0, bits[0]};
        MAH_SA_REG_ARM: r = {1'b1, 31'h0, bits[1]};
        MAH_SA_REG_LEVEL: r = {1'b1, 31'h0, bits[2]};
        MAH_SA_LATCHED_POS: r = {1'b1, lpos};
        default: r = 33'h0;
      endcase
    end else if (obj == MAH_OBJ_POSC) begin
      case (id)
        MAH_PA_NUM_ATTR: r = {1'b1, MAH_NUM_ATTR_VAL};
        MAH_PA_MODE: r = {1'b1, 30'h0, p.mode};
        MAH_PA_TARGET: r = {1'b1, p.target};
        MAH_PA_SPEED: r = {1'b1, p.speed};
        MAH_PA_ACCEL: r = {1'b1, p.accel};
        MAH_PA_DECEL: r = {1'b1, p.decel};
        MAH_PA_INCR: r = {1'b1, 31'h0, p.incremental};
        MAH_PA_LOAD: r = {1'b1, 31'h0, bits[3]};
        MAH_PA_ON_TARGET: r = {1'b1, 31'h0, on_target};
        MAH_PA_ACT_POS: r = {1'b1, apos};
        MAH_PA_ACT_VEL: r = {1'b1, avel};
        default: r = 33'h0;
      endcase
    end
    return r;
  endfunction

  // objects other than the two known ones set and arm nothing and read as zero, but their load bit still updates load_q
  assign obj_ok = (cmd.object_sel == MAH_OBJ_SUPER) || (cmd.object_sel == MAH_OBJ_POSC);
  assign load_rise = cmd_valid && cmd.flags[MAH_CB_LOAD] && !load_q;
  assign set_super = load_rise && (cmd.object_sel == MAH_OBJ_SUPER);
  assign set_posc = load_rise && (cmd.object_sel == MAH_OBJ_POSC);

  always_comb begin
    load_d = load_q;
    if (cmd_valid) begin
      load_d = cmd.flags[MAH_CB_LOAD];
    end
  end

  // arm follows each command to either known object, explicit set also allowed
  always_comb begin
    arm_load = cmd_valid && obj_ok;
    arm_value = cmd.flags[MAH_CB_ARM];
    if (set_super && cmd.set_attr == MAH_SA_REG_ARM) begin
      arm_value = cmd.value[0];
    end
  end

  always_comb begin
    prof_d = prof_q;
    start_d = 1'b0;
    pload_d = 1'b0;
    pval_d = pval_q;
    if (cmd_valid && obj_ok) begin
      prof_d.incremental = cmd.flags[MAH_CB_INCR];
    end
    // value written only on load edge
    if (set_posc) begin
      start_d = 1'b1;
      // read-only and unknown ids fall to default
      case (cmd.set_attr)
        // mode, torque is the highest code
        MAH_PA_MODE: begin
          if (cmd.value[31:0] <= 32'h2) begin
            prof_d.mode = cmd.value[1:0];
          end
        end
        MAH_PA_TARGET: prof_d.target = cmd.value;
        MAH_PA_SPEED: prof_d.speed = cmd.value;
        MAH_PA_ACCEL: prof_d.accel = cmd.value;
        MAH_PA_DECEL: prof_d.decel = cmd.value;
        MAH_PA_INCR: prof_d.incremental = cmd.value[0];
        MAH_PA_ACT_POS: begin
          pload_d = 1'b1;
          pval_d = cmd.value;
        end
        // flag-driven incremental update above must survive a refused set
        default: pload_d = 1'b0;
      endcase
    end
  end

  always_comb begin
    logic [32:0] g;
    g = read_attr(cmd.object_sel, cmd.get_attr, prof_q,
        {profile_busy, reg_level, armed, home_level}, latched_position,
        measured_position, measured_speed);
    get_hit = g[32];
    get_val = g[31:0];
    rsp_d = rsp_q;
    if (cmd_valid) begin
      rsp_d.flags = 8'h0;
      rsp_d.flags[MAH_RB_BUSY] = profile_busy;
      rsp_d.flags[MAH_RB_ON_TGT] = on_target;
      rsp_d.flags[MAH_RB_HOME] = home_level;
      rsp_d.flags[MAH_RB_REG] = reg_level;
      rsp_d.get_attr = cmd.get_attr;
      rsp_d.object_echo = {cmd.instance_sel, cmd.object_sel};
      rsp_d.ok = {7'h0, get_hit && obj_ok};
      rsp_d.value = get_hit ? get_val : 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      load_q <= 1'b0;
      prof_q <= '{target: 32'sh0, speed: MAH_SPEED_RST, accel: MAH_RATE_RST,
                  decel: MAH_RATE_RST, incremental: 1'b0, mode: MAH_MODE_RST};
      rsp_q <= '0;
      rsp_valid_q <= 1'b0;
      start_q <= 1'b0;
      pload_q <= 1'b0;
      pval_q <= 32'sh0;
    end else begin
      load_q <= load_d;
      prof_q <= prof_d;
      rsp_q <= rsp_d;
      rsp_valid_q <= cmd_valid;
      start_q <= start_d;
      pload_q <= pload_d;
      pval_q <= pval_d;
    end
  end

  // start pulses on every load edge to the position controller object, so new data and a move come together
  assign profile = prof_q;
  assign start_move = start_q;
  assign position_load = pload_q;
  assign position_load_value = pval_q;
  assign rsp = rsp_q;
  assign rsp_valid = rsp_valid_q;
endmodule
